/* File: wdtc_pkg.sv */
/*
  wdtc_pkg: register map, field layout, reset values and timing constants
  for the watchdog timer block.
  assumes: 32-bit apb data, one aligned word per register, pclk at 250 mhz.
*/
package wdtc_pkg;

  // register byte addresses
  localparam logic [11:0] WDTC_OFS_CONTROL = 12'h000;
  localparam logic [11:0] WDTC_OFS_STATUS = 12'h004;
  localparam logic [11:0] WDTC_OFS_MASK = 12'h008;
  localparam logic [11:0] WDTC_OFS_COUNT = 12'h00C;

  // control register layout
  localparam int WDTC_PS_LSB = 0;
  localparam int WDTC_PS_W = 5;
  localparam int WDTC_SWEN_BIT = 8;

  // status and mask layout
  localparam int WDTC_ST_TIMEOUT = 0;
  localparam int WDTC_ST_PWRDN = 1;
  localparam int WDTC_ST_W = 2;

  // period ladder: code n gives 2**n time-base ticks of 1 ms
  localparam logic [4:0] WDTC_PS_RESET = 5'h0B;
  localparam logic [4:0] WDTC_PS_MAX = 5'h12;
  localparam int WDTC_CNT_W = 19;

  // enable configuration encodings
  localparam logic [1:0] WDTC_EN_OFF = 2'h0;
  localparam logic [1:0] WDTC_EN_SW = 2'h1;
  localparam logic [1:0] WDTC_EN_AWAKE = 2'h2;
  localparam logic [1:0] WDTC_EN_ON = 2'h3;

  // timing
  localparam int WDTC_CLK_PERIOD_NS = 4;
  localparam int WDTC_TICK_NS = 1000000;
  localparam int WDTC_TICK_CYCLES = WDTC_TICK_NS / WDTC_CLK_PERIOD_NS;

  // sleep sequencing states
  typedef enum logic [1:0] {
    WDTC_AWAKE = 2'b00,
    WDTC_ASLEEP = 2'b01,
    WDTC_STARTUP_HOLD = 2'b10
  } wdtc_state_e;

endpackage : wdtc_pkg

/* File: wdtc_tick.sv */
/*
  wdtc_tick: low-speed time base for the watchdog, one pulse per tick period.
  assumes: clr restarts the tick period so a cleared watchdog starts a full tick.
*/
`timescale 1ns/1ns
`default_nettype none
module wdtc_tick
  import wdtc_pkg::*;
#(
  parameter int TICK_CYCLES = WDTC_TICK_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  output logic tick
);

  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam logic [PW-1:0] LAST = PW'(TICK_CYCLES - 1);

  logic [PW-1:0] pre_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_r <= '0;
      tick <= 1'b0;
    end
    else if (clr)
    begin
      pre_r <= '0;
      tick <= 1'b0;
    end
    else if (pre_r == LAST)
    begin
      pre_r <= '0;
      tick <= 1'b1;
    end
    else
    begin
      pre_r <= pre_r + PW'(1);
      tick <= 1'b0;
    end
  end

endmodule : wdtc_tick
`default_nettype wire

/* File: wdtc_top.sv */
/*
  wdtc_top: watchdog timer with apb register access, sleep handling and a
  masked level interrupt on its sticky status flags.
  assumes: system inputs are synchronous to pclk; sleep_active is a level
  that is high while the device sleeps; clear_instr and osc_fail are
  levels or pulses; presetn is asserted on every device reset.
*/
`timescale 1ns/1ns
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Contract
// - period select field picks time-outs from 1 ms to 256 s nominal
// - after any reset period select reads two seconds
// - count clears on reset, clear instruction, osc fail, disable, start-up timer
// - count clears on entering sleep
// - if still enabled in sleep, count resumes from zero
// - count clears again on wake-up
// - exit with crystal clock holds count clear until start-up timer ends
// - exit with other clock sources just clears, no hold
// - time-out during sleep produces no reset
// - time-out during sleep wakes the device instead
// - time-out sets timeout flag in status, and also the power-down flag when it happens in sleep
// - held clear when config 00, or 01 with software enable low
// - config 10 clears and holds inactive during sleep
// - changing internal oscillator divider leaves the count alone
module wdtc_top
  import wdtc_pkg::*;
#(
  parameter int TICK_CYCLES = WDTC_TICK_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] watchdog_enable_config,
  input wire logic sleep_active,
  input wire logic crystal_mode,
  input wire logic clear_instr,
  input wire logic osc_fail,
  input wire logic oscillator_startup_timer,
  input wire logic [3:0] internal_osc_divider_select,
  output logic watchdog_reset,
  output logic wake,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////
  // helpers

  // terminal count for a period code, clamped to the longest period
  function automatic logic [WDTC_CNT_W-1:0] period_last(input logic [4:0] ps);
    logic [4:0] n;
    n = (ps > WDTC_PS_MAX) ? WDTC_PS_MAX : ps;
    period_last = (WDTC_CNT_W'(1) << n) - WDTC_CNT_W'(1);
  endfunction : period_last

  function automatic logic is_reg(input logic [11:0] a);
    is_reg = (a == WDTC_OFS_CONTROL) || (a == WDTC_OFS_STATUS) ||
             (a == WDTC_OFS_MASK) || (a == WDTC_OFS_COUNT);
  endfunction : is_reg

  //////////////////////////////////////////////////////////////////////////
  // declarations

  logic [4:0] period_sel_r;
  logic sw_enable_r;
  logic [WDTC_ST_W-1:0] status_r;
  logic [WDTC_ST_W-1:0] mask_r;
  logic [WDTC_CNT_W-1:0] count_r;
  logic [31:0] prdata_r;
  wdtc_state_e state_r;
  logic sleep_q_r;
  logic startup_q_r;
  logic enabled;
  logic hold_clear;
  logic tick;
  logic expire;
  logic sleep_enter;
  logic sleep_exit;
  logic wr_en;
  logic rd_access;
  logic [WDTC_ST_W-1:0] status_set;
  logic [WDTC_ST_W-1:0] status_nxt;

  //////////////////////////////////////////////////////////////////////////
  // apb decode

  assign pready = 1'b1;
  assign pslverr = psel && penable && !is_reg(paddr);
  assign prdata = prdata_r;
  assign wr_en = psel && penable && pwrite && is_reg(paddr);
  assign rd_access = psel && penable && !pwrite;

  // read data is captured in the setup cycle and held through access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= '0;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata_r <= '0;
      case (paddr)
        WDTC_OFS_CONTROL:
        begin
          prdata_r[WDTC_PS_LSB +: WDTC_PS_W] <= period_sel_r;
          prdata_r[WDTC_SWEN_BIT] <= sw_enable_r;
        end
        WDTC_OFS_STATUS:
        begin
          prdata_r[WDTC_ST_W-1:0] <= status_r;
        end
        WDTC_OFS_MASK:
        begin
          prdata_r[WDTC_ST_W-1:0] <= mask_r;
        end
        WDTC_OFS_COUNT:
        begin
          prdata_r[WDTC_CNT_W-1:0] <= count_r;
        end
        default:
        begin
          prdata_r <= '0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control and mask registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      period_sel_r <= WDTC_PS_RESET;
      sw_enable_r <= 1'b0;
    end
    else if (wr_en && paddr == WDTC_OFS_CONTROL)
    begin
      period_sel_r <= pwdata[WDTC_PS_LSB +: WDTC_PS_W];
      sw_enable_r <= pwdata[WDTC_SWEN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_r <= '0;
    end
    else if (wr_en && paddr == WDTC_OFS_MASK)
    begin
      mask_r <= pwdata[WDTC_ST_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // enable and sleep sequencing

  always_comb
  begin
    case (watchdog_enable_config)
      WDTC_EN_OFF: enabled = 1'b0;
      WDTC_EN_SW: enabled = sw_enable_r;
      WDTC_EN_AWAKE: enabled = !sleep_active;
      WDTC_EN_ON: enabled = 1'b1;
      default: enabled = 1'b0;
    endcase
  end

  assign sleep_enter = sleep_active && !sleep_q_r;
  assign sleep_exit = !sleep_active && sleep_q_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sleep_q_r <= 1'b0;
      startup_q_r <= 1'b0;
    end
    else
    begin
      sleep_q_r <= sleep_active;
      startup_q_r <= oscillator_startup_timer;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= WDTC_AWAKE;
    end
    else
    begin
      case (state_r)
        WDTC_AWAKE:
        begin
          if (sleep_enter)
          begin
            state_r <= WDTC_ASLEEP;
          end
        end
        WDTC_ASLEEP:
        begin
          if (sleep_exit)
          begin
            // crystal sources wait for the start-up timer to finish
            state_r <= crystal_mode ? WDTC_STARTUP_HOLD : WDTC_AWAKE;
          end
        end
        WDTC_STARTUP_HOLD:
        begin
          if (sleep_enter)
          begin
            state_r <= WDTC_ASLEEP;
          end
          // apart from a new sleep entry, the hold ends only on a falling edge of the start-up timer
          else if (startup_q_r && !oscillator_startup_timer)
          begin
            state_r <= WDTC_AWAKE;
          end
        end
        default:
        begin
          state_r <= WDTC_AWAKE;
        end
      endcase
    end
  end

  // the divider select does not appear here, so it never disturbs the count
  assign hold_clear = !enabled || clear_instr || osc_fail || oscillator_startup_timer ||
                      sleep_enter || sleep_exit || (state_r == WDTC_STARTUP_HOLD);

  //////////////////////////////////////////////////////////////////////////
  // time base and counter

  wdtc_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .clr(hold_clear),
    .tick(tick)
  );

  // a time-out restarts the count, so each period runs in full from zero
  assign expire = !hold_clear && tick && (count_r >= period_last(period_sel_r));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_r <= '0;
    end
    else if (hold_clear || expire)
    begin
      count_r <= '0;
    end
    else if (tick)
    begin
      count_r <= count_r + WDTC_CNT_W'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // time-out actions

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      watchdog_reset <= 1'b0;
      wake <= 1'b0;
    end
    else
    begin
      watchdog_reset <= expire && !sleep_active;
      wake <= expire && sleep_active;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status flags and interrupt

  always_comb
  begin
    status_set = '0;
    status_set[WDTC_ST_TIMEOUT] = expire;
    status_set[WDTC_ST_PWRDN] = expire && sleep_active;
  end

  // a read clears only the flags it returned, so a flag set during setup survives
  always_comb
  begin
    status_nxt = status_r | status_set;
    if (rd_access && paddr == WDTC_OFS_STATUS)
    begin
      status_nxt = (status_r & ~prdata_r[WDTC_ST_W-1:0]) | status_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_r <= '0;
    end
    else
    begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(status_nxt & mask_r);
    end
  end

endmodule : wdtc_top
`default_nettype wire

/* File: wdtc_monitor.sv */
/* wdtc_monitor: port-level assertions for the watchdog top.
   assumes: bound into wdtc_top, one pclk domain. */
`timescale 1ns/1ns
`default_nettype none
module wdtc_monitor #(
  parameter int TICK_CYCLES = 4
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [1:0] watchdog_enable_config,
  input wire logic sleep_active,
  input wire logic clear_instr,
  input wire logic osc_fail,
  input wire logic oscillator_startup_timer,
  input wire logic watchdog_reset,
  input wire logic wake,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////////
  sequence s_pulse;
    watchdog_reset || wake;
  endsequence
  chk_reset_awake: assert property (watchdog_reset |-> !$past(sleep_active))
    else $error("reset pulse after a sleeping cycle");
  chk_wake_asleep: assert property (wake |-> $past(sleep_active))
    else $error("wake pulse after an awake cycle");
  chk_pulse_single: assert property (s_pulse |=> !watchdog_reset && !wake)
    else $error("time-out pulse longer than one cycle");
  chk_hold_quiet: assert property ($past(clear_instr || osc_fail || oscillator_startup_timer)
    |-> !watchdog_reset && !wake) else $error("time-out while a clear was held");
  chk_off_quiet: assert property ($past(watchdog_enable_config) == 2'h0
    |-> !watchdog_reset && !wake) else $error("time-out while disabled");
  chk_cfg_awake: assert property ($past(watchdog_enable_config == 2'h2 && sleep_active)
    |-> !wake) else $error("wake while awake-only config sleeps");
  chk_sleep_edge: assert property ($past(sleep_active) != $past(sleep_active, 2)
    |-> !watchdog_reset && !wake) else $error("time-out at a sleep edge");
  chk_irq_cause: assert property ($rose(irq) |-> watchdog_reset || wake
    || $past(psel && penable && pwrite, 2)) else $error("irq rose with no cause");
  // cycles since the last time-out pulse, saturated at one tick
  int gap_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap_r <= TICK_CYCLES;
    end
    else if (watchdog_reset || wake)
    begin
      gap_r <= 1;
    end
    else if (gap_r < TICK_CYCLES)
    begin
      gap_r <= gap_r + 1;
    end
  end
  chk_pulse_gap: assert property (s_pulse |-> gap_r >= TICK_CYCLES)
    else $error("time-out pulses closer than one tick");
endmodule : wdtc_monitor
`default_nettype wire

/* File: wdtc_test.sv */
/* wdtc_test: directed bench for wdtc_top over apb and system pins.
   assumes: TICK_CYCLES of 4, design answers apb by pready. */
`timescale 1ns/1ns
`default_nettype none
module wdtc_test import wdtc_pkg::*;;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, watchdog_reset, wake, irq, err;
  logic [1:0] cfg = 2'h3;
  logic slp = 1'h0, xtal = 1'h0, clr = 1'h0, ofail = 1'h0, startup = 1'h0;
  logic [3:0] div = 4'h0;
  int n_errors = 0, checks = 0, n_rst = 0, n_wake = 0, cyc = 0;
  wdtc_top #(.TICK_CYCLES(4)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .watchdog_enable_config(cfg), .sleep_active(slp),
    .crystal_mode(xtal), .clear_instr(clr), .osc_fail(ofail),
    .oscillator_startup_timer(startup), .internal_osc_divider_select(div), .watchdog_reset,
    .wake, .irq);
  initial
  begin
    forever #2 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  always @(posedge pclk)
  begin
    if (watchdog_reset === 1'h1)
      n_rst <= n_rst + 1;
    if (wake === 1'h1)
      n_wake <= n_wake + 1;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // restart by clear, start-up timer fall or sleep exit, then time the next pulse
  task automatic gap(input int k, input int n, input logic w);
    int r, q, c;
    case (k)
      0: clr <= 1'h1;
      1: startup <= 1'h1;
      default: slp <= 1'h0;
    endcase
    @(posedge pclk);
    clr <= 1'h0;
    startup <= 1'h0;
    div <= div + 4'h5;
    @(posedge pclk);
    r = n_rst;
    q = n_wake;
    c = 0;
    while (n_rst == r && n_wake == q && c < 300)
    begin
      @(posedge pclk);
      c++;
    end
    chk("period window", 32'h1, 32'(c >= (4 << n) - 2 && c <= (4 << n) + 4));
    chk("wake pulses", 32'(w), 32'(n_wake - q));
  endtask : gap
  task automatic quiet(input logic [1:0] c, input int k, input logic [31:0] ctl);
    int r;
    cfg <= c;
    clr <= 1'(k == 1);
    ofail <= 1'(k == 2);
    startup <= 1'(k == 3);
    apb(1'h1, WDTC_OFS_CONTROL, ctl);
    r = n_rst + n_wake;
    repeat (80) @(posedge pclk);
    chk("pulses while held", 32'(r), 32'(n_rst + n_wake));
  endtask : quiet
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(1'h0, WDTC_OFS_CONTROL, 32'h0);
    chk("control reset", 32'h0000000B, rd);
    apb(1'h0, 12'h010, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    apb(1'h1, WDTC_OFS_MASK, 32'h3);
    apb(1'h0, WDTC_OFS_MASK, 32'h0);
    chk("mask", 32'h3, rd);
    $display("test regs done");
  endtask : t_regs
  task automatic t_ladder();
    for (int n = 0; n < 5; n += 2)
    begin
      apb(1'h1, WDTC_OFS_CONTROL, 32'h100 | 32'(n));
      gap(0, n, 1'h0);
    end
    cfg <= 2'h0;
    repeat (3) @(posedge pclk);
    chk("irq raised", 32'h1, 32'(irq));
    apb(1'h0, WDTC_OFS_STATUS, 32'h0);
    chk("status awake", 32'h1, rd);
    apb(1'h0, WDTC_OFS_STATUS, 32'h0);
    chk("status cleared", 32'h0, rd);
    chk("irq cleared", 32'h0, 32'(irq));
    $display("test ladder done");
  endtask : t_ladder
  task automatic t_quiet();
    quiet(2'h0, 0, 32'h102);
    quiet(2'h1, 0, 32'h002);
    quiet(2'h3, 1, 32'h102);
    apb(1'h0, WDTC_OFS_COUNT, 32'h0);
    chk("count held", 32'h0, rd);
    quiet(2'h3, 2, 32'h102);
    quiet(2'h3, 3, 32'h102);
    quiet(2'h1, 2, 32'h102);
    ofail <= 1'h0;
    gap(0, 2, 1'h0);
    $display("test quiet done");
  endtask : t_quiet
  task automatic t_sleep();
    apb(1'h0, WDTC_OFS_STATUS, 32'h0);
    cfg <= 2'h3;
    slp <= 1'h1;
    gap(0, 2, 1'h1);
    cfg <= 2'h0;
    apb(1'h0, WDTC_OFS_STATUS, 32'h0);
    chk("status asleep", 32'h3, rd);
    quiet(2'h2, 0, 32'h102);
    xtal <= 1'h1;
    slp <= 1'h0;
    quiet(2'h3, 0, 32'h102);
    gap(1, 2, 1'h0);
    slp <= 1'h1;
    xtal <= 1'h0;
    repeat (4) @(posedge pclk);
    gap(2, 2, 1'h0);
    $display("test sleep done");
  endtask : t_sleep
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_ladder();
    t_quiet();
    t_sleep();
    print_verdict();
  end
endmodule : wdtc_test
bind wdtc_top wdtc_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.pclk, .presetn, .psel,
  .penable, .pwrite, .watchdog_enable_config, .sleep_active, .clear_instr, .osc_fail,
  .oscillator_startup_timer, .watchdog_reset, .wake, .irq);
`default_nettype wire
